// file: verilog/fault_gpio_pkg.sv
package fault_gpio_pkg;

  // Register offsets on the internal register port.
  localparam logic [7:0] POSITIVE_FAULT_STATUS_ADDR = 8'h12;
  localparam logic [7:0] NEGATIVE_FAULT_STATUS_ADDR = 8'h13;
  localparam logic [7:0] GENERAL_PURPOSE_PINS_ADDR  = 8'h14;

  // Values after reset, and the value read at an unmapped offset.
  localparam logic [7:0] FAULT_STATUS_RESET    = 8'h00;
  localparam logic [3:0] PIN_DATA_RESET        = 4'h0;
  localparam logic [3:0] PIN_DIRECTION_RESET   = 4'hF;
  localparam logic [7:0] UNMAPPED_READ_VALUE   = 8'h00;

  // Field positions in the general-purpose pin register.
  localparam int PIN_DATA_LSB      = 4;
  localparam int PIN_DIRECTION_LSB = 0;

  // Widths: channels, pins and the input level code.
  localparam int CHANNELS = 8;
  localparam int PINS     = 4;
  localparam int LEVEL_W  = 10;

  // Comparator thresholds in tenths of a percent of full scale, indexed by the select code.
  localparam logic [0:7][9:0] HIGH_THRESHOLD = '{10'h3B6, 10'h39D, 10'h384, 10'h36B,
                                                 10'h352, 10'h320, 10'h2EE, 10'h2BC};
  localparam logic [0:7][9:0] LOW_THRESHOLD  = '{10'h032, 10'h04B, 10'h064, 10'h07D,
                                                 10'h096, 10'h0C8, 10'h0FA, 10'h12C};

  // One register access from the serial command decoder.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : fault_gpio_pkg

// file: verilog/fault_comparator_bank.sv
`timescale 1ns/1ps
module fault_comparator_bank #(
  parameter int CHANNELS = 8,
  parameter int LEVEL_W  = 10
) (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic [2:0]                       comparator_threshold_select,
  input  wire logic [CHANNELS-1:0][LEVEL_W-1:0] level_pos,
  input  wire logic [CHANNELS-1:0][LEVEL_W-1:0] level_neg,
  output logic      [CHANNELS-1:0]              fault_pos,
  output logic      [CHANNELS-1:0]              fault_neg
);

  logic [LEVEL_W-1:0] high_th;
  logic [LEVEL_W-1:0] low_th;

  // Pick both window edges from the shared select code.
  assign high_th = LEVEL_W'(fault_gpio_pkg::HIGH_THRESHOLD[comparator_threshold_select]); // [R10]
  assign low_th  = LEVEL_W'(fault_gpio_pkg::LOW_THRESHOLD[comparator_threshold_select]);  // [R10]

  ////////////////////////////////////////////////////////////////////////////////
  // One comparator pair per channel; a pin is faulty outside the window.
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_cmp
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        fault_pos[ch] <= 1'b0;
        fault_neg[ch] <= 1'b0;
      end else begin
        fault_pos[ch] <= (level_pos[ch] > high_th) || (level_pos[ch] < low_th); // [R4]
        fault_neg[ch] <= (level_neg[ch] > high_th) || (level_neg[ch] < low_th); // [R4]
      end
    end
  end

endmodule : fault_comparator_bank

// file: verilog/fault_status_and_gpio_regs.sv
`timescale 1ns/1ps
// What this block does
// [R1] Positive fault flags, channel 8 bit 7.
// [R2] Negative fault flags, channel 8 bit 7.
// [R3] Fault registers read-only, cleared at reset.
// [R4] Flags from comparing pins against threshold.
// [R5] Pin register: data high, direction low.
// [R6] Data read returns actual pin levels.
// [R7] Data write drives output pins.
// [R8] Data write ignored for input pins.
// [R9] Direction 0 output, 1 input; reset 0Fh.
// [R10] Threshold code selects high/low window edges.
// [R11] Flags track comparators through a synchroniser.
module fault_status_and_gpio_regs #(
  parameter int CHANNELS = fault_gpio_pkg::CHANNELS,
  parameter int PINS     = fault_gpio_pkg::PINS,
  parameter int LEVEL_W  = fault_gpio_pkg::LEVEL_W
) (
  input  wire logic                             REF_CLK_I,
  input  wire logic                             RST_N_I,
  input  wire fault_gpio_pkg::reg_req_s         REG_REQ_I,
  input  wire logic [2:0]                       COMP_THRESHOLD_SEL_I,
  input  wire logic [CHANNELS-1:0][LEVEL_W-1:0] PIN_LEVEL_POS_I,
  input  wire logic [CHANNELS-1:0][LEVEL_W-1:0] PIN_LEVEL_NEG_I,
  input  wire logic [PINS-1:0]                  GPIO_IN_I,
  output logic      [7:0]                       REG_RDATA_O,
  output logic      [PINS-1:0]                  GPIO_OUT_O,
  output logic      [PINS-1:0]                  GPIO_OE_O
);

  logic [CHANNELS-1:0] cmp_pos;
  logic [CHANNELS-1:0] cmp_neg;
  logic [CHANNELS-1:0] sync1_pos;
  logic [CHANNELS-1:0] sync1_neg;
  logic [7:0]          positive_fault_status;
  logic [7:0]          negative_fault_status;
  logic [PINS-1:0]     pin_direction_bits;
  logic [7:0]          next_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator bank turns the input levels into raw fault flags.
  fault_comparator_bank #(
    .CHANNELS (CHANNELS),
    .LEVEL_W  (LEVEL_W)
  ) u_cmp (
    .clk                         (REF_CLK_I),
    .rst_n                       (RST_N_I),
    .comparator_threshold_select (COMP_THRESHOLD_SEL_I),
    .level_pos                   (PIN_LEVEL_POS_I),
    .level_neg                   (PIN_LEVEL_NEG_I),
    .fault_pos                   (cmp_pos),
    .fault_neg                   (cmp_neg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; the status registers are the second stage.
  // Flags follow the comparators and are never latched or cleared by a read.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      sync1_pos             <= '0;
      sync1_neg             <= '0;
      positive_fault_status <= fault_gpio_pkg::FAULT_STATUS_RESET; // [R3]
      negative_fault_status <= fault_gpio_pkg::FAULT_STATUS_RESET; // [R3]
    end else begin
      sync1_pos             <= cmp_pos;   // [R11]
      sync1_neg             <= cmp_neg;   // [R11]
      positive_fault_status <= 8'(sync1_pos); // [R1]
      negative_fault_status <= 8'(sync1_neg); // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Direction bits and the matching output enables; enable is high while driving.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pin_direction_bits <= fault_gpio_pkg::PIN_DIRECTION_RESET; // [R9]
      GPIO_OE_O          <= ~fault_gpio_pkg::PIN_DIRECTION_RESET;
    end else if (REG_REQ_I.wr && REG_REQ_I.addr == fault_gpio_pkg::GENERAL_PURPOSE_PINS_ADDR) begin
      pin_direction_bits <= REG_REQ_I.wdata[fault_gpio_pkg::PIN_DIRECTION_LSB +: PINS]; // [R5]
      GPIO_OE_O          <= ~REG_REQ_I.wdata[fault_gpio_pkg::PIN_DIRECTION_LSB +: PINS]; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output data: a write lands only on pins that are outputs by the old direction.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      GPIO_OUT_O <= fault_gpio_pkg::PIN_DATA_RESET;
    end else if (REG_REQ_I.wr && REG_REQ_I.addr == fault_gpio_pkg::GENERAL_PURPOSE_PINS_ADDR) begin
      for (int p = 0; p < PINS; p++) begin
        if (!pin_direction_bits[p]) begin
          GPIO_OUT_O[p] <= REG_REQ_I.wdata[fault_gpio_pkg::PIN_DATA_LSB + p]; // [R7]
        end // Input pins keep their value. [R8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; status registers accept no write.
  always_comb begin
    case (REG_REQ_I.addr)
      fault_gpio_pkg::POSITIVE_FAULT_STATUS_ADDR: next_rdata = positive_fault_status; // [R1]
      fault_gpio_pkg::NEGATIVE_FAULT_STATUS_ADDR: next_rdata = negative_fault_status; // [R2]
      fault_gpio_pkg::GENERAL_PURPOSE_PINS_ADDR:
        next_rdata = {GPIO_IN_I, pin_direction_bits}; // [R6]
      default: next_rdata = fault_gpio_pkg::UNMAPPED_READ_VALUE;
    endcase
  end

  // Read data is captured on a read request and held until the next one.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_REQ_I.rd) begin
      REG_RDATA_O <= next_rdata; // [R3]
    end
  end

endmodule : fault_status_and_gpio_regs

// file: testbench/fault_gpio_sva.sv
`timescale 1ns/1ps
// Watches the register port and the pin outputs of the block.
module fault_gpio_sva #(parameter int PINS = 4) (
  input wire logic                     REF_CLK_I,
  input wire logic                     RST_N_I,
  input wire fault_gpio_pkg::reg_req_s REG_REQ_I,
  input wire logic [PINS-1:0]          GPIO_IN_I,
  input wire logic [7:0]               REG_RDATA_O,
  input wire logic [PINS-1:0]          GPIO_OUT_O,
  input wire logic [PINS-1:0]          GPIO_OE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Marks a write or a read of the pin register.
  wire pw = REG_REQ_I.wr && REG_REQ_I.addr == 8'h14;
  wire pr = REG_REQ_I.rd && REG_REQ_I.addr == 8'h14;
  chk_pin_read_data: assert property (
    pr |=> REG_RDATA_O[7:4] == $past(GPIO_IN_I)) else $error("pin data read wrong");
  chk_dir_read_back: assert property (
    pr |=> REG_RDATA_O[3:0] == ~$past(GPIO_OE_O)) else $error("direction read wrong");
  chk_dir_write: assert property (
    pw |=> GPIO_OE_O == ~$past(REG_REQ_I.wdata[3:0])) else $error("direction write wrong");
  chk_out_pin_write: assert property (
    pw |=> (GPIO_OUT_O & $past(GPIO_OE_O)) == ($past(REG_REQ_I.wdata[7:4]) & $past(GPIO_OE_O)))
    else $error("output data wrong");
  chk_in_pin_kept: assert property (
    ##1 ((GPIO_OUT_O ^ $past(GPIO_OUT_O)) & ~$past(GPIO_OE_O)) == 0) else $error("input pin moved");
  chk_status_no_write: assert property (
    REG_REQ_I.wr && !pw |=> $stable(GPIO_OE_O) && $stable(GPIO_OUT_O)) else $error("side write");
  chk_unmapped_zero: assert property (
    REG_REQ_I.rd && (REG_REQ_I.addr < 8'h12 || REG_REQ_I.addr > 8'h14) |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  chk_reset_state: assert property (
    disable iff (1'b0) !RST_N_I |=> GPIO_OE_O == 0 && REG_RDATA_O == 8'h00) else $error("reset");
endmodule : fault_gpio_sva

// file: testbench/gpio_pin_world.sv
`timescale 1ns/1ps
// Resolves the four pins from the block's drive and an outside source.
module gpio_pin_world (
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] out_i,
  input  wire logic [3:0] ext_i,
  output logic      [3:0] pin_o
);
  // A driven pin shows the block's value, an undriven one the outside level.
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : gpio_pin_world

// file: testbench/tb_fault_status_and_gpio_regs.sv
`timescale 1ns/1ps
module tb_fault_status_and_gpio_regs;
  logic                     clk = 0, rst_n = 0;
  fault_gpio_pkg::reg_req_s req = '0;
  logic [2:0]               sel = '0, s;
  // Levels start mid-scale so that no flag is legitimately set after reset.
  logic [7:0][9:0]          lp = {8{10'h1F4}}, ln = {8{10'h1F4}}, a, b;
  logic [9:0]               hi, lo;
  logic [3:0]               ext = '0, pin, out, oe;
  logic [7:0]               rdata;
  int                       error_cnt = 0, compares = 0, cyc = 0;
  fault_status_and_gpio_regs i_fault_status_and_gpio_regs (.REF_CLK_I(clk), .RST_N_I(rst_n),
    .REG_REQ_I(req), .COMP_THRESHOLD_SEL_I(sel), .PIN_LEVEL_POS_I(lp), .PIN_LEVEL_NEG_I(ln),
    .GPIO_IN_I(pin), .REG_RDATA_O(rdata), .GPIO_OUT_O(out), .GPIO_OE_O(oe));
  gpio_pin_world i_gpio_pin_world (.oe_i(oe), .out_i(out), .ext_i(ext), .pin_o(pin));
  ////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic [7:0] ad, input logic w, input logic [7:0] d);
    @(posedge clk) req <= '{ad, w, !w, d};
    @(posedge clk) req <= '0;
    #1;
  endtask : acc
  function automatic logic [7:0] flags(input logic [7:0][9:0] l, input logic [2:0] t);
    for (int c = 0; c < 8; c++) flags[c] = l[c] > fault_gpio_pkg::HIGH_THRESHOLD[t]
                                          || l[c] < fault_gpio_pkg::LOW_THRESHOLD[t];
  endfunction : flags
  task stop_test;
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////
  // Clock of 20 ns and a cycle limit that cuts a hang short.
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  // Register and pin checks first, then random levels against every threshold code.
  initial begin
    void'($urandom(24962));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    ext   <= 4'h9;
    acc(8'h12, 0, 8'h00); chk(rdata, 8'h00);
    acc(8'h14, 0, 8'h00); chk(rdata, 8'h9F);
    acc(8'h14, 1, 8'hA0); chk({out, oe}, 8'h0F);
    acc(8'h14, 1, 8'hA5); chk({out, oe}, 8'hAA);
    acc(8'h14, 0, 8'h00); chk(rdata, 8'hB5);
    acc(8'h14, 1, 8'h30); chk({out, oe}, 8'h2F);
    acc(8'h12, 1, 8'hFF);
    acc(8'h13, 1, 8'hFF); chk({out, oe}, 8'h2F);
    acc(8'h20, 0, 8'h00); chk(rdata, 8'h00);
    for (int i = 0; i < 16; i++) begin
      s  = i[2:0];
      hi = fault_gpio_pkg::HIGH_THRESHOLD[s];
      lo = fault_gpio_pkg::LOW_THRESHOLD[s];
      for (int c = 0; c < 8; c++) begin
        a[c] = 10'($urandom_range(1000));
        b[c] = 10'($urandom_range(1000));
      end
      a[0] = hi;
      a[1] = hi + 10'h001;
      b[2] = lo;
      b[3] = lo - 10'h001;
      @(posedge clk) begin
        sel <= s;
        lp  <= a;
        ln  <= b;
        ext <= 4'($urandom);
      end
      repeat (3) @(posedge clk);
      acc(8'h12, 0, 8'h00); chk(rdata, flags(a, s));
      acc(8'h13, 0, 8'h00); chk(rdata, flags(b, s));
      acc(8'h14, 1, 8'($urandom));
    end
    @(posedge clk) rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    acc(8'h12, 0, 8'h00); chk(rdata, 8'h00);
    chk({out, oe}, 8'h00);
    stop_test();
  end
endmodule : tb_fault_status_and_gpio_regs

bind fault_status_and_gpio_regs fault_gpio_sva #(.PINS(PINS)) i_fault_gpio_sva (.REF_CLK_I,
  .RST_N_I, .REG_REQ_I, .GPIO_IN_I, .REG_RDATA_O, .GPIO_OUT_O, .GPIO_OE_O);
